// ===== hdl/acr_regs.svh
/*
 * Offsets, field codes, reset values and sizes for the status and
 * calibration register access block.
 * Assumes it is included by its bare name and holds definitions only.
 */
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// ============================================================
// Word and frame sizes
`define ACR_WORD_W     16
`define ACR_CAL_W      14
`define ACR_CAL_NUM    10
`define ACR_FRAME_BITS 5'h10

// ============================================================
// Calibration register indices (pointer values)
`define ACR_IDX_GAIN   4'h0
`define ACR_IDX_OFFSET 4'h1
`define ACR_IDX_LAST   4'h9

// ============================================================
// Calibration target select codes
`define ACR_SEL_ALL    2'h0
`define ACR_SEL_GO     2'h1
`define ACR_SEL_OFF    2'h2
`define ACR_SEL_GAIN   2'h3

// ============================================================
// Read target select codes
`define ACR_RD_CAL     2'h2
`define ACR_RD_STAT    2'h3

// ============================================================
// Write target code in the top two bits of a host frame
`define ACR_WR_CTRL    2'h1
`define ACR_WR_CAL     2'h3

// ============================================================
// Reset values
`define ACR_CTRL_RST   14'h0000
`define ACR_CAL_RST    14'h2000

`endif

// ===== hdl/acr_pkg.sv
/*
 * Types for the status and calibration register access block.
 * Assumes acr_regs.svh is on the include path.
 */
`default_nettype none
`include "acr_regs.svh"

package acr_pkg;

    // Control register layout, bit 13 down to bit 0
    typedef struct packed {
        logic       input_config_select;
        logic [2:0] channel_select;
        logic [1:0] power_mgmt;
        logic [1:0] read_target_select;
        logic       mode_select;
        logic       conv_start;
        logic       calibration_kind;
        logic [1:0] cal_target_select;
        logic       calibration_start;
    } acr_ctrl_t;

    // Write of one coefficient by the calibration engine
    typedef struct packed {
        logic                   valid;
        logic [3:0]             idx;
        logic [`ACR_CAL_W-1:0]  data;
    } acr_upd_t;

    // Serial frame states, one-hot
    typedef enum logic [1:0] {
        ACR_IDLE  = 2'b01,
        ACR_SHIFT = 2'b10
    } acr_frame_t;

endpackage : acr_pkg

`default_nettype wire

// ===== hdl/acr_top.sv
/*
 * Status word and calibration register access over the serial port.
 * Assumes the conversion and calibration engines run on SYS_CLK and that
 * the serial clock, frame and data pins are asynchronous to it.
 */
// Functional notes
// RL1: Status bit 15 always reads zero.
// RL2: Bit 14 shows conversion or calibration busy.
// RL3: Bits 13..10 show input config and channel.
// RL4: Bits 9..8 show power management field.
// RL5: Bits 7..6 read as ones.
// RL6: Bit 5 mode; cleared after every read.
// RL7: Bit 3 shows calibration kind.
// RL8: Bit 0 shows calibration in progress.
// RL9: Bits 2..1 show calibration target select.
// RL10: Ten readable, writable calibration registers.
// RL11: Calibration engine updates registers automatically.
// RL12: Target select code picks access set.
// RL13: Same decoding for reads and writes.
// RL14: Host sets targets before calibration access.
// RL15: Pointer resets on control write, sequence end.
// RL16: Reset pointer: gain, or offset if alone.
// RL17: Pointer advances after each multi-register access.
// RL18: Early stop; next control write resets pointer.
// RL19: Calibration reads carry two leading zeros.
// RL20: Mode 1 host completes all calibration reads.
// RL21: Read select 11 picks status word.
// RL22: Status word read-only, zero at power-up; bits 7..6 still read as ones here.
// RL23: Offset, gain hold fourteen bits, two zeros.
// RL24: Order: gain, offset, then DAC ascending.
`default_nettype none
`include "acr_regs.svh"

module acr_top (
    input  wire logic                   SYS_CLK,
    input  wire logic                   RESET,
    input  wire logic                   SCLK,
    input  wire logic                   SYNC_N,
    input  wire logic                   DIN,
    output logic                        DOUT,
    output logic                        DOUT_OE_N,
    input  wire logic                   CONV_BUSY,
    input  wire logic                   CAL_BUSY,
    input  wire logic [11:0]            CONV_RESULT,
    input  wire acr_pkg::acr_upd_t      CAL_UPD,
    output acr_pkg::acr_ctrl_t          CTRL
);

    // ============================================================
    // State

    // Whole state of the block in one word
    typedef struct packed {
        acr_pkg::acr_ctrl_t                     ctrl;    // Control register
        logic [3:0]                             ptr;     // Calibration pointer
        logic [`ACR_CAL_NUM-1:0][`ACR_CAL_W-1:0] cal;    // Coefficients
        logic [2:0]                             sclk_s;  // Sync pair plus edge history
        logic [2:0]                             sync_s;  // Sync pair plus edge history
        logic [1:0]                             din_s;   // Sync pair
        acr_pkg::acr_frame_t                    fsm;     // Frame state
        logic [4:0]                             cnt;     // Bits taken this frame
        logic [`ACR_WORD_W-1:0]                 rx;      // Word shifted in
        logic [`ACR_WORD_W-1:0]                 tx;      // Word shifted out
        logic                                   rd_cal;  // Frame reads a coefficient
        logic                                   conv_d;  // Busy history for falling edges
        logic                                   cal_d;
    } acr_state_t;

    acr_state_t r;          // Registered state
    acr_state_t next_r;     // Next state

    // ============================================================
    // Pointer arithmetic

    // First register of a selected sequence
    function automatic logic [3:0] first_idx(input logic [1:0] sel);
        // RL16 offset-only starts elsewhere
        first_idx = (sel == `ACR_SEL_OFF) ? `ACR_IDX_OFFSET : `ACR_IDX_GAIN;
    endfunction : first_idx

    // Last register of a selected sequence
    function automatic logic [3:0] last_idx(input logic [1:0] sel);
        // RL12 size of each access set
        unique case (sel)
            `ACR_SEL_ALL: last_idx = `ACR_IDX_LAST;
            `ACR_SEL_GO:  last_idx = `ACR_IDX_OFFSET;
            `ACR_SEL_OFF: last_idx = `ACR_IDX_OFFSET;
            `ACR_SEL_GAIN: last_idx = `ACR_IDX_GAIN;
        endcase
    endfunction : last_idx

    // Pointer after one access; wraps to the start after the last one
    function automatic logic [3:0] step_idx(input logic [3:0] p, input logic [1:0] sel);
        // RL15 wrap at sequence end
        if (p == last_idx(sel)) begin
            step_idx = first_idx(sel);
        end else begin
            // RL24 gain, offset, DAC upward
            step_idx = 4'(p + 4'h1);
        end
    endfunction : step_idx

    // ============================================================
    // Status word and edges

    logic [`ACR_WORD_W-1:0] status_w;   // Status word as read
    logic                   sclk_rise;  // Serial clock edges
    logic                   sclk_fall;
    logic                   frame_go;   // Frame starts
    logic                   frame_end;  // Frame ends with a full word
    logic                   busy_any;   // Conversion or calibration running

    // Status word is built from live state, so it is never stale
    always_comb begin
        busy_any = CONV_BUSY | CAL_BUSY;
        // RL1 RL2 RL3 RL4 RL5 status layout
        // RL6 RL7 RL8 RL9 RL21 RL22 status layout
        status_w = {1'b0, busy_any, r.ctrl.input_config_select, r.ctrl.channel_select,
                    r.ctrl.power_mgmt, 2'h3, r.ctrl.mode_select, 1'b0,
                    r.ctrl.calibration_kind, r.ctrl.cal_target_select, CAL_BUSY};
        // Edges come from the second stage and its history, never the first
        sclk_rise = r.sclk_s[1] & ~r.sclk_s[2];
        sclk_fall = ~r.sclk_s[1] & r.sclk_s[2];
        frame_go  = ~r.sync_s[1] & r.sync_s[2] & (r.fsm == acr_pkg::ACR_IDLE);
        frame_end = r.sync_s[1] & ~r.sync_s[2] & (r.fsm == acr_pkg::ACR_SHIFT)
                    & (r.cnt == `ACR_FRAME_BITS);
    end

    // ============================================================
    // Next state

    // Frame handling, register writes and pointer updates
    always_comb begin
        next_r = r;
        next_r.sclk_s = {r.sclk_s[1:0], SCLK};
        next_r.sync_s = {r.sync_s[1:0], SYNC_N};
        next_r.din_s  = {r.din_s[0], DIN};
        next_r.conv_d = CONV_BUSY;
        next_r.cal_d  = CAL_BUSY;

        // Start bits drop when their engine finishes
        if (r.conv_d & ~CONV_BUSY) begin
            next_r.ctrl.conv_start = 1'b0;
        end
        if (r.cal_d & ~CAL_BUSY) begin
            next_r.ctrl.calibration_start = 1'b0;
        end

        unique case (r.fsm)
            acr_pkg::ACR_IDLE: begin
                // Load the read word at frame start
                if (frame_go) begin
                    next_r.fsm    = acr_pkg::ACR_SHIFT;
                    next_r.cnt    = 5'h00;
                    next_r.rd_cal = (r.ctrl.read_target_select == `ACR_RD_CAL);
                    if (r.ctrl.read_target_select == `ACR_RD_STAT) begin
                        next_r.tx = status_w;
                    end else if (r.ctrl.read_target_select == `ACR_RD_CAL) begin
                        // RL19 RL23 two leading zeros
                        next_r.tx = {2'h0, r.cal[r.ptr]};
                    end else begin
                        // Conversion result with four leading zeros
                        next_r.tx = {4'h0, CONV_RESULT};
                    end
                end
            end
            acr_pkg::ACR_SHIFT: begin
                // Data in on rising edges, out on falling edges
                if (sclk_rise && r.cnt != `ACR_FRAME_BITS) begin
                    next_r.rx  = {r.rx[14:0], r.din_s[1]};
                    next_r.cnt = 5'(r.cnt + 5'h01);
                end
                if (sclk_fall) begin
                    next_r.tx = {r.tx[14:0], 1'b0};
                end
                // A short frame is dropped with no effect
                if (r.sync_s[1] & ~r.sync_s[2]) begin
                    next_r.fsm = acr_pkg::ACR_IDLE;
                end
                if (frame_end) begin
                    if (r.rx[15:14] == `ACR_WR_CTRL) begin
                        next_r.ctrl = acr_pkg::acr_ctrl_t'(r.rx[13:0]);
                        // RL15 RL18 control write resets pointer
                        next_r.ptr = first_idx(r.rx[2:1]);
                    end else begin
                        // RL6 mode bit clears after a read cycle
                        next_r.ctrl.mode_select = 1'b0;
                        if (r.rx[15:14] == `ACR_WR_CAL) begin
                            // RL10 RL13 host write at pointer
                            next_r.cal[r.ptr] = r.rx[13:0];
                            // RL17 advance after write
                            next_r.ptr = step_idx(r.ptr, r.ctrl.cal_target_select);
                        end else if (r.rd_cal) begin
                            // RL17 advance after read
                            next_r.ptr = step_idx(r.ptr, r.ctrl.cal_target_select);
                        end
                    end
                end
            end
        endcase

        // RL11 engine updates win over the host
        if (CAL_UPD.valid && CAL_UPD.idx <= `ACR_IDX_LAST) begin
            next_r.cal[CAL_UPD.idx] = CAL_UPD.data;
        end
    end

    // ============================================================
    // Registers

    // Whole state in one register; power-up values match the defaults
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            r.ctrl   <= acr_pkg::acr_ctrl_t'(`ACR_CTRL_RST);
            r.ptr    <= `ACR_IDX_GAIN;
            r.cal    <= {`ACR_CAL_NUM{`ACR_CAL_RST}};
            // Both link lines idle high; a low history here would
            // show a false edge on the first cycles after reset
            r.sclk_s <= 3'h7;
            r.sync_s <= 3'h7;
            r.din_s  <= 2'h0;
            r.fsm    <= acr_pkg::ACR_IDLE;
            r.cnt    <= 5'h00;
            r.rx     <= 16'h0000;
            r.tx     <= 16'h0000;
            r.rd_cal <= 1'b0;
            r.conv_d <= 1'b0;
            r.cal_d  <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ============================================================
    // Outputs

    // Pin driven only inside a frame so several parts may share it
    assign DOUT      = r.tx[15];
    assign DOUT_OE_N = (r.fsm != acr_pkg::ACR_SHIFT);
    assign CTRL      = r.ctrl;

    // ============================================================
    // Checks

    // Checks watch registered state one cycle after the event that moves
    // it. Short frames never reach frame_end, so any pointer or coefficient
    // change that they cause shows up as a failure of the hold checks further down.

    // RL1 RL5 status top bits
    chk_status_msb_zero: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL1 RL5
        frame_go && r.ctrl.read_target_select == `ACR_RD_STAT |=> !r.tx[15] && r.tx[7:6] == 2'h3)
        else $error("status word msb or select bits wrong");

    // RL2 RL8 live busy bits
    chk_status_busy_bit: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL2 RL8
        status_w[14] == (CONV_BUSY | CAL_BUSY) && status_w[0] == CAL_BUSY)
        else $error("status busy bits disagree with engines");

    // RL3 RL4 RL7 RL9 control fields
    chk_status_ctrl_fields: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL3 RL4 RL7 RL9
        status_w[13:8] == {r.ctrl.input_config_select, r.ctrl.channel_select, r.ctrl.power_mgmt}
        && status_w[3:1] == {r.ctrl.calibration_kind, r.ctrl.cal_target_select})
        else $error("status fields disagree with control");

    // RL2 RL8 loaded busy bits
    chk_status_busy_load: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL2 RL8
        frame_go && r.ctrl.read_target_select == `ACR_RD_STAT
        |=> r.tx[14] == $past(CONV_BUSY | CAL_BUSY) && r.tx[0] == $past(CAL_BUSY))
        else $error("loaded status busy bits wrong");

    // RL6 mode bit read back
    chk_status_mode_load: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL6
        frame_go && r.ctrl.read_target_select == `ACR_RD_STAT |=> r.tx[5] == $past(r.ctrl.mode_select))
        else $error("loaded status mode bit wrong");

    // RL6 mode clears on read
    chk_mode_read_clear: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL6
        frame_end && r.rx[15:14] != `ACR_WR_CTRL |=> !r.ctrl.mode_select)
        else $error("mode bit kept after read cycle");

    // RL21 control word stored
    chk_ctrl_word_load: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL21
        frame_end && r.rx[15:14] == `ACR_WR_CTRL |=> r.ctrl == acr_pkg::acr_ctrl_t'($past(r.rx[13:0])))
        else $error("control word not stored as sent");

    // RL15 RL16 pointer restart
    chk_ptr_ctrl_reset: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL15 RL16
        frame_end && r.rx[15:14] == `ACR_WR_CTRL
        |=> r.ptr == ((r.ctrl.cal_target_select == `ACR_SEL_OFF) ? `ACR_IDX_OFFSET : `ACR_IDX_GAIN))
        else $error("pointer not reset by control write");

    // RL12 RL16 pointer within set
    chk_ptr_in_set: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL12 RL16
        (r.ctrl.cal_target_select == `ACR_SEL_ALL && r.ptr <= `ACR_IDX_LAST)
        || (r.ctrl.cal_target_select == `ACR_SEL_GO && r.ptr <= `ACR_IDX_OFFSET)
        || (r.ctrl.cal_target_select == `ACR_SEL_OFF && r.ptr == `ACR_IDX_OFFSET)
        || (r.ctrl.cal_target_select == `ACR_SEL_GAIN && r.ptr == `ACR_IDX_GAIN))
        else $error("pointer outside selected set");

    // RL17 RL24 single step
    chk_ptr_step_one: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL17 RL24
        frame_end && r.rx[15:14] != `ACR_WR_CTRL && (r.rx[15:14] == `ACR_WR_CAL || r.rd_cal)
        && r.ctrl.cal_target_select == `ACR_SEL_ALL && r.ptr != `ACR_IDX_LAST
        |=> r.ptr == 4'($past(r.ptr) + 4'h1))
        else $error("pointer did not advance by one");

    // RL15 wrap after last
    chk_ptr_wrap_end: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL15
        frame_end && r.rx[15:14] != `ACR_WR_CTRL && (r.rx[15:14] == `ACR_WR_CAL || r.rd_cal)
        && r.ctrl.cal_target_select == `ACR_SEL_ALL && r.ptr == `ACR_IDX_LAST
        |=> r.ptr == `ACR_IDX_GAIN)
        else $error("pointer did not restart after last register");

    // RL17 RL18 pointer holds between frames
    chk_ptr_hold_idle: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL17 RL18
        !frame_end |=> r.ptr == $past(r.ptr))
        else $error("pointer moved without a finished frame");

    // RL19 RL23 calibration read word
    chk_cal_lead_zero: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL19 RL23
        frame_go && r.ctrl.read_target_select == `ACR_RD_CAL |=> r.tx[15:14] == 2'h0 ##1 DOUT_OE_N == 1'b0)
        else $error("calibration read lacks leading zeros");

    // RL19 RL23 coefficient under leading zeros
    chk_cal_read_word: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL19 RL23
        frame_go && r.ctrl.read_target_select == `ACR_RD_CAL |=> r.tx[13:0] == $past(r.cal[r.ptr]))
        else $error("calibration read word wrong");

    // RL11 engine update stored
    chk_engine_update: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL11
        CAL_UPD.valid && CAL_UPD.idx <= `ACR_IDX_LAST
        |=> r.cal[$past(CAL_UPD.idx)] == $past(CAL_UPD.data))
        else $error("engine coefficient not stored");

    // RL10 RL13 host write stored
    chk_host_cal_write: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL10 RL13
        frame_end && r.rx[15:14] == `ACR_WR_CAL && !CAL_UPD.valid
        |=> r.cal[$past(r.ptr)] == $past(r.rx[13:0]))
        else $error("host coefficient write lost");

    // RL10 RL11 coefficients hold otherwise
    chk_cal_hold_idle: assert property (@(posedge SYS_CLK) disable iff (RESET) // RL10 RL11
        !frame_end && !CAL_UPD.valid |=> r.cal == $past(r.cal))
        else $error("coefficient changed without a writer");

endmodule : acr_top

`default_nettype wire

// ===== testbench/acr_host_model.sv
/*
 * Host side of the serial link: frames one 16-bit word out on the data
 * pin while taking the returned word from the data-out pin.
 * Assumes the caller starts a frame only after the previous one ended.
 */
`default_nettype none

module acr_host_model (
    input  wire logic SYS_CLK,
    output logic      SCLK,
    output logic      SYNC_N,
    output logic      DIN,
    input  wire logic DOUT,
    input  wire logic DOUT_OE_N
);
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // Idle levels: clock high, frame off
    initial begin
        SCLK   = 1'b1;
        SYNC_N = 1'b1;
        DIN    = 1'b0;
    end

    // ============================================================
    // One frame, MSB first; 64 ns link period, unrelated to SYS_CLK
    // Output bits are taken just before each falling edge, since the
    // device moves to the next bit only after it sees that edge.
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx, output logic oe_low);
        @(negedge SYS_CLK);
        SYNC_N = 1'b0;
        DIN    = tx[15];
        #32;
        // Pin should already be driven by now
        oe_low = ~DOUT_OE_N;
        for (int i = 15; i >= 0; i--) begin
            DIN   = tx[i];
            rx[i] = DOUT;
            SCLK  = 1'b0;
            #32;
            SCLK  = 1'b1;
            #32;
        end
        SYNC_N = 1'b1;
        // Released data line shows the inverse, never a stale bit
        DIN    = ~tx[0];
        // Gap covers synchroniser delay and the minimum high time
        #100;
    endtask : frame

endmodule : acr_host_model

`default_nettype wire

// ===== testbench/adc_status_and_cal_register_access_bench.sv
/*
 * Self-checking bench for the status and calibration register block.
 * Assumes acr_pkg and acr_top are compiled first, host model alongside.
 */
`default_nettype none

module adc_status_and_cal_register_access_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic               sys_clk;
    logic               reset;
    logic               sclk;
    logic               sync_n;
    logic               din;
    logic               dout;
    logic               dout_oe_n;
    logic               conv_busy;
    logic               cal_busy;
    logic [11:0]        conv_result;
    acr_pkg::acr_upd_t  cal_upd;
    acr_pkg::acr_ctrl_t ctrl;
    int                 bad_count;
    int                 checks_done;
    logic [15:0]        rx;
    logic               oe;

    acr_top acr_top_inst (
        .SYS_CLK(sys_clk), .RESET(reset), .SCLK(sclk), .SYNC_N(sync_n),
        .DIN(din), .DOUT(dout), .DOUT_OE_N(dout_oe_n), .CONV_BUSY(conv_busy),
        .CAL_BUSY(cal_busy), .CONV_RESULT(conv_result), .CAL_UPD(cal_upd), .CTRL(ctrl)
    );

    acr_host_model acr_host_model_inst (
        .SYS_CLK(sys_clk), .SCLK(sclk), .SYNC_N(sync_n), .DIN(din),
        .DOUT(dout), .DOUT_OE_N(dout_oe_n)
    );

    // ============================================================
    // Clock, 200 MHz
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ============================================================
    // Checking helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Frame with returned word and driven pin both judged
    task automatic xfer(input logic [15:0] tx, input logic [15:0] exp);
        acr_host_model_inst.frame(tx, rx, oe);
        chk(rx, exp);
        chk({15'h0, oe}, 16'h0001);
    endtask : xfer

    // Control write; the register must take the word as sent
    task automatic ctl(input logic [13:0] c);
        acr_host_model_inst.frame({2'h1, c}, rx, oe);
        chk({2'h0, ctrl}, {2'h0, c});
    endtask : ctl

    task automatic tally_and_finish;
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // ============================================================
    // Scenarios
    task automatic test_reset;
        chk({2'h0, ctrl}, 16'h0000);
        chk({15'h0, dout_oe_n}, 16'h0001);
    endtask : test_reset

    // Config 1, channel 5, power 2, status select, mode 1, system cal, set 01
    task automatic test_status;
        // Status word selected for reading
        ctl(14'h36EA);
        @(negedge sys_clk) conv_busy = 1'b1;
        xfer(16'h0000, 16'h76EA);
        chk({15'h0, ctrl.mode_select}, 16'h0000);
        @(negedge sys_clk) conv_busy = 1'b0;
        cal_busy = 1'b1;
        xfer(16'h0000, 16'h76CB);
        @(negedge sys_clk) cal_busy = 1'b0;
        xfer(16'h0000, 16'h36CA);
    endtask : test_status

    // Full set: reset contents, then writes, then reads in index order
    task automatic test_cal_all;
        // Targets set before any calibration access
        ctl(14'h0080);
        for (int i = 0; i < 10; i++) xfer(16'h0000, 16'h2000);
        ctl(14'h0000);
        for (int i = 0; i < 10; i++) xfer({2'h3, 14'h0100 + 14'(i)}, {4'h0, conv_result});
        ctl(14'h0080);
        for (int i = 0; i < 10; i++) xfer(16'h0000, 16'h0100 + 16'(i));
        xfer(16'h0000, 16'h0100);
    endtask : test_cal_all

    // Smaller sets, three reads each, expected pointer per read
    task automatic test_sets;
        logic [3:0] idx [1:3][0:2];
        idx[1] = '{4'h0, 4'h1, 4'h0};
        idx[2] = '{4'h1, 4'h1, 4'h1};
        idx[3] = '{4'h0, 4'h0, 4'h0};
        for (int s = 1; s <= 3; s++) begin
            ctl(14'h0080 | (14'(s) << 1));
            for (int k = 0; k < 3; k++) xfer(16'h0000, 16'h0100 + 16'(idx[s][k]));
        end
        // Aborted walk, then a fresh control write
        ctl(14'h0080);
        for (int k = 0; k < 3; k++) xfer(16'h0000, 16'h0100 + 16'(k));
        ctl(14'h0080);
        xfer(16'h0000, 16'h0100);
    endtask : test_sets

    // Engine writes gain and offset; an out-of-range index is dropped
    task automatic test_engine;
        @(negedge sys_clk) cal_upd = '{1'b1, 4'h0, 14'h1ABC};
        @(negedge sys_clk) cal_upd = '{1'b1, 4'h1, 14'h0DEF};
        @(negedge sys_clk) cal_upd = '{1'b1, 4'hA, 14'h3FFF};
        @(negedge sys_clk) cal_upd = '{1'b0, 4'h0, 14'h0000};
        ctl(14'h0082);
        xfer(16'h0000, 16'h1ABC);
        xfer(16'h0000, 16'h0DEF);
        ctl(14'h0000);
        // Out-of-range engine word must leave the DAC set as written
        ctl(14'h0080);
        xfer(16'h0000, 16'h1ABC);
        xfer(16'h0000, 16'h0DEF);
        for (int i = 2; i < 10; i++) xfer(16'h0000, 16'h0100 + 16'(i));
    endtask : test_engine

    // ============================================================
    // Main sequence
    initial begin
        bad_count   = 0;
        checks_done = 0;
        reset       = 1'b1;
        conv_busy   = 1'b0;
        cal_busy    = 1'b0;
        conv_result = 12'hA5C;
        cal_upd     = '{1'b0, 4'h0, 14'h0000};
        repeat (10) @(negedge sys_clk);
        test_reset();
        reset = 1'b0;
        // Frame detection needs the frame line high a few cycles first
        repeat (5) @(negedge sys_clk);
        test_status();
        test_cal_all();
        test_sets();
        test_engine();
        tally_and_finish();
    end

    // Hang guard: a run past this point is a failure
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end

endmodule : adc_status_and_cal_register_access_bench

`default_nettype wire
